// ===== include/iid_defs.svh
/*
 * Register offsets, field positions, reset values and checksum constants
 * for the interface identifier block.
 * Assumes byte addressing on a 32-bit register port; included by bare name.
 */
`ifndef IID_DEFS_SVH
`define IID_DEFS_SVH

// Byte offsets of the 32-bit register words
`define IID_OFF_ID_LO 8'h00
`define IID_OFF_ID_HI 8'h04
`define IID_OFF_CSUM_EN 8'h08
`define IID_OFF_CSUM_RES 8'h0c

// Field positions inside the 64-bit identifier
`define IID_POS_DEVICE 48
`define IID_POS_VENDOR 32
`define IID_POS_REVISION 24
`define IID_POS_CAPABLE 23
`define IID_POS_RSVD 20

// Reset and fixed read values
`define IID_RST_CSUM_EN 1'b0
`define IID_RST_CSUM_RES 16'h0000
`define IID_ABSENT_READ 32'h0000_00ff
`define IID_UNMAPPED_READ 32'h0000_0000

// Checksum: CRC-16 seed and polynomial
`define IID_CRC_SEED 16'hffff
`define IID_CRC_POLY 16'h1021

// Cycles from the last byte of a frame to the published result
`define IID_RESULT_LAT 1

`endif

// ===== include/iid_pkg.sv
/*
 * Types for the interface identifier block: bus request, byte stream,
 * identifier layout and checksum frame states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package iid_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} iid_req_s;

	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
	} iid_stream_s;

	typedef struct packed {
		logic [15:0] device_code;
		logic [15:0] vendor_code;
		logic [7:0] revision_code;
		logic checksum_capable;
		logic [2:0] reserved;
		logic [19:0] lower;
	} iid_ident_s;

	typedef enum logic {
		iid_idle,
		iid_in_frame
	} iid_frame_e;

endpackage

// ===== rtl/iid_crc16.sv
/*
 * Byte-wide CRC-16 accumulator for command and response data.
 * Assumes the caller decides which bytes belong to a frame.
 */
`timescale 1ns/1ps
`include "iid_defs.svh"

module iid_crc16 (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic start,
	input wire logic take,
	input wire logic [7:0] data,
	output logic [15:0] crc,
	output logic [15:0] crc_next
);

	function automatic logic [15:0] crc_byte(input logic [15:0] acc, input logic [7:0] b);
		logic [15:0] c;
		c = acc ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ `IID_CRC_POLY) : (c << 1);
		end
		crc_byte = c;
	endfunction

	// A start byte folds into the seed, so a frame needs no idle cycle
	assign crc_next = crc_byte(start ? `IID_CRC_SEED : crc, data);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			crc <= `IID_CRC_SEED;
		end else if (take) begin
			crc <= crc_next;
		end
	end

endmodule // iid_crc16

// ===== rtl/iid_ident.sv
/*
 * Builds the constant 64-bit interface identifier from parameters.
 * Assumes the caller registers whatever it drives out of the chip.
 */
`timescale 1ns/1ps
`include "iid_defs.svh"

module iid_ident #(
	parameter logic [15:0] DEVICE_CODE = 16'h0001,
	parameter logic [15:0] VENDOR_CODE = 16'h5a5a,
	parameter logic [7:0] REVISION_CODE = 8'h01,
	parameter bit CHECKSUM_CAPABLE = 1'b1,
	parameter logic [19:0] LOWER_FIELDS = 20'h00000
) (
	output iid_pkg::iid_ident_s ident
);

	// Most significant byte of the code lands in the low field byte
	function automatic logic [15:0] big_endian(input logic [15:0] code);
		big_endian = {code[7:0], code[15:8]};
	endfunction

	assign ident.device_code = DEVICE_CODE;
	assign ident.vendor_code = big_endian(VENDOR_CODE);
	assign ident.revision_code = REVISION_CODE;
	assign ident.checksum_capable = CHECKSUM_CAPABLE;
	assign ident.reserved = 3'h0;
	assign ident.lower = LOWER_FIELDS;

endmodule // iid_ident

// ===== rtl/iid_top.sv
/*
 * Interface identifier register with optional data checksum registers.
 * Assumes a same-clock register master (one-cycle strobes, read data one
 * cycle later) and a same-clock byte stream marking frame first and last.
 */
// Notes on behaviour
// RULE_01: Writes to the checksum capability bit are dropped; its value never changes.
// RULE_02: Without checksum capability, reads of both checksum registers return 0xFF.
// RULE_03: With checksum capability, enable and result registers both exist and respond.
// RULE_04: Vendor code sits in bits 47:32, most significant byte in the low field byte.
// RULE_05: Revision code is read-only in identifier bits 31:24.
// RULE_06: Bit 23 reports checksum capability; the enable register switches checksums on.
// RULE_07: The checksum always covers a whole command or response frame, never part.
// RULE_08: Reserved bits 22:20 read zero, device code in 63:48, writes to both ignored.
`timescale 1ns/1ps
`include "iid_defs.svh"

module iid_top #(
	parameter int DEVICE_CODE = 16'h0001,
	parameter int VENDOR_CODE = 16'h5a5a, // Arbitrary value
	parameter int REVISION_CODE = 8'h01,
	parameter int CHECKSUM_CAPABLE = 1,
	parameter int LOWER_FIELDS = 20'h00000
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire iid_pkg::iid_req_s bus,
	output logic [31:0] rd_data,
	input wire iid_pkg::iid_stream_s stream,
	output logic csum_enable,
	output logic [15:0] csum_result,
	output logic csum_done
);

	if (DEVICE_CODE < 0 || DEVICE_CODE > 16'hffff) begin : g_chk_dev
		$error("DEVICE_CODE must fit in 16 bits");
	end
	if (VENDOR_CODE < 0 || VENDOR_CODE > 16'hffff) begin : g_chk_ven
		$error("VENDOR_CODE must fit in 16 bits");
	end
	if (REVISION_CODE < 0 || REVISION_CODE > 8'hff) begin : g_chk_rev
		$error("REVISION_CODE must fit in 8 bits");
	end
	if (CHECKSUM_CAPABLE != 0 && CHECKSUM_CAPABLE != 1) begin : g_chk_cap
		$error("CHECKSUM_CAPABLE must be 0 or 1");
	end
	if (LOWER_FIELDS < 0 || LOWER_FIELDS > 20'hfffff) begin : g_chk_low
		$error("LOWER_FIELDS must fit in 20 bits");
	end

	localparam logic CAP = CHECKSUM_CAPABLE[0];
	localparam logic [15:0] VENDOR = VENDOR_CODE[15:0];

	iid_pkg::iid_ident_s ident;
	iid_pkg::iid_frame_e frame_state;
	logic [63:0] ident_word;
	logic [15:0] crc_acc;
	logic [15:0] crc_next;
	logic crc_start;
	logic crc_take;
	logic frame_finish;
	logic frame_abort;

	function automatic logic hit(input iid_pkg::iid_req_s r, input logic [7:0] off);
		hit = (r.addr == off);
	endfunction

	iid_ident #(
		.DEVICE_CODE(DEVICE_CODE[15:0]),
		.VENDOR_CODE(VENDOR),
		.REVISION_CODE(REVISION_CODE[7:0]),
		.CHECKSUM_CAPABLE(CAP),
		.LOWER_FIELDS(LOWER_FIELDS[19:0])
	) u_ident (
		.ident(ident)
	);

	// Identifier is wired from constants, so there is no write path at all
	assign ident_word = ident; // RULE_01 RULE_08

	// Enable register exists only on capable parts
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			csum_enable <= `IID_RST_CSUM_EN;
		end else if (bus.wr && hit(bus, `IID_OFF_CSUM_EN) && CAP) begin
			csum_enable <= bus.wdata[0]; // RULE_03 RULE_06
		end
	end

	// A frame counts only if checksumming was on from its first byte
	assign crc_start = stream.valid && stream.first && csum_enable;
	assign crc_take = crc_start || (stream.valid && frame_state == iid_pkg::iid_in_frame && csum_enable);
	assign frame_finish = crc_take && stream.last; // RULE_07
	assign frame_abort = frame_state == iid_pkg::iid_in_frame && !csum_enable;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			frame_state <= iid_pkg::iid_idle;
		end else begin
			case (frame_state)
				iid_pkg::iid_idle: begin
					if (crc_start && !stream.last) begin
						frame_state <= iid_pkg::iid_in_frame;
					end
				end
				iid_pkg::iid_in_frame: begin
					// Disabling mid-frame drops the partial sum unpublished
					if (frame_finish || frame_abort) begin
						frame_state <= iid_pkg::iid_idle; // RULE_07
					end
				end
				default: begin
					frame_state <= iid_pkg::iid_idle;
				end
			endcase
		end
	end

	iid_crc16 u_crc (
		.clock(clock),
		.arst_n(arst_n),
		.start(crc_start),
		.take(crc_take),
		.data(stream.data),
		.crc(crc_acc),
		.crc_next(crc_next)
	);

	// Result updates only at a frame's last byte
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			csum_result <= `IID_RST_CSUM_RES;
		end else if (frame_finish) begin
			csum_result <= crc_next; // RULE_07
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			csum_done <= 1'b0;
		end else begin
			csum_done <= frame_finish;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= `IID_UNMAPPED_READ;
		end else if (!bus.rd) begin
			rd_data <= `IID_UNMAPPED_READ;
		end else if (hit(bus, `IID_OFF_ID_LO)) begin
			rd_data <= ident_word[31:0]; // RULE_05 RULE_06 RULE_08
		end else if (hit(bus, `IID_OFF_ID_HI)) begin
			rd_data <= ident_word[63:32]; // RULE_04 RULE_08
		end else if (hit(bus, `IID_OFF_CSUM_EN)) begin
			rd_data <= CAP ? {31'h0000_0000, csum_enable} : `IID_ABSENT_READ; // RULE_02 RULE_03
		end else if (hit(bus, `IID_OFF_CSUM_RES)) begin
			rd_data <= CAP ? {16'h0000, csum_result} : `IID_ABSENT_READ; // RULE_02 RULE_03
		end else begin
			rd_data <= `IID_UNMAPPED_READ;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_id_lo_write;
		bus.wr && hit(bus, `IID_OFF_ID_LO);
	endsequence

	sequence s_id_lo_read;
		bus.rd && hit(bus, `IID_OFF_ID_LO);
	endsequence

	sequence s_id_hi_read;
		bus.rd && hit(bus, `IID_OFF_ID_HI);
	endsequence

	sequence s_csum_read;
		bus.rd && (hit(bus, `IID_OFF_CSUM_EN) || hit(bus, `IID_OFF_CSUM_RES));
	endsequence

	a_cap_write_ignored: assert property ( // RULE_01
		s_id_lo_write ##1 s_id_lo_read |=> rd_data[`IID_POS_CAPABLE] == CAP)
		else $error("capability bit changed after a write");

	a_absent_csum_ff: assert property ( // RULE_02
		s_csum_read and (!CAP) |=> rd_data == `IID_ABSENT_READ)
		else $error("absent checksum register did not read 0xff");

	a_enable_reachable: assert property ( // RULE_03
		CAP && bus.wr && hit(bus, `IID_OFF_CSUM_EN) ##1 bus.rd && hit(bus, `IID_OFF_CSUM_EN)
		|=> rd_data == {31'h0000_0000, $past(bus.wdata[0], 2)})
		else $error("checksum enable did not read back");

	a_vendor_order: assert property ( // RULE_04
		s_id_hi_read |=> rd_data[7:0] == VENDOR[15:8] && rd_data[15:8] == VENDOR[7:0])
		else $error("vendor code not big-endian");

	a_revision_field: assert property ( // RULE_05
		s_id_lo_read |=> rd_data[31:24] == REVISION_CODE[7:0])
		else $error("revision code wrong");

	a_cap_bit_value: assert property ( // RULE_06
		s_id_lo_read |=> rd_data[`IID_POS_CAPABLE] == CAP)
		else $error("capability bit wrong");

	a_enable_needs_cap: assert property ( // RULE_06
		!CAP |-> !csum_enable)
		else $error("checksum enabled on a part without it");

	a_whole_frame: assert property ( // RULE_07
		$changed(csum_result) |-> $past(stream.valid && stream.last && csum_enable) && csum_done)
		else $error("checksum published outside a frame end");

	a_frame_done_pulse: assert property ( // RULE_07
		csum_done |-> ##1 !csum_done || $past(frame_finish, 1))
		else $error("checksum done pulse held");

	a_reserved_zero: assert property ( // RULE_08
		s_id_lo_read |=> rd_data[22:20] == 3'h0)
		else $error("reserved bits not zero");

	a_device_code: assert property ( // RULE_08
		s_id_hi_read |=> rd_data[31:16] == DEVICE_CODE[15:0])
		else $error("device code wrong");

	a_idle_read_zero: assert property (
		!bus.rd |=> rd_data == `IID_UNMAPPED_READ)
		else $error("read data stood without a read");

	sequence s_enable_write;
		bus.wr && hit(bus, `IID_OFF_CSUM_EN);
	endsequence

	sequence s_result_write;
		bus.wr && hit(bus, `IID_OFF_CSUM_RES);
	endsequence

	a_enable_write: assert property ( // RULE_03
		s_enable_write and (CAP) |=> csum_enable == $past(bus.wdata[0]))
		else $error("checksum enable write not taken");

	// Result is published by frames only, never by software
	a_result_write_ro: assert property ( // RULE_03
		s_result_write and (!frame_finish) |=> $stable(csum_result))
		else $error("checksum result changed by a write");

	a_abort_quiet: assert property ( // RULE_07
		frame_abort |=> !csum_done)
		else $error("aborted frame was published");

	a_absent_no_done: assert property ( // RULE_02
		!CAP |-> !csum_done)
		else $error("checksum done on a part without it");

endmodule // iid_top

// ===== verification/tb_top.sv
/*
 * Self-checking bench for the interface identifier block: identifier words,
 * read-only fields, checksum registers with and without capability, frames.
 * Assumes iid_pkg and iid_defs.svh are compiled and on the include path.
 */
`timescale 1ns/1ps
`include "iid_defs.svh"

module tb_top;
	localparam int DEV = 16'h0bd2; // Arbitrary value
	localparam int VEND = 16'hc3a7; // Arbitrary value
	localparam int REV = 8'h3c;

	logic clock;
	logic arst_n;
	iid_pkg::iid_req_s bus;
	iid_pkg::iid_stream_s stream;
	logic [31:0] rd_data;
	logic [31:0] rd_data_nc;
	logic csum_enable;
	logic csum_enable_nc;
	logic csum_done;
	logic csum_done_nc;
	logic [15:0] csum_result;
	logic [15:0] csum_result_nc;
	logic [31:0] d;
	logic [31:0] dn;
	logic [15:0] e;
	logic [15:0] e2;
	int failures;
	int compares;

	iid_top #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEND), .REVISION_CODE(REV), .CHECKSUM_CAPABLE(1)) uut (
		.clock(clock), .arst_n(arst_n), .bus(bus), .rd_data(rd_data), .stream(stream),
		.csum_enable(csum_enable), .csum_result(csum_result), .csum_done(csum_done));

	// Second copy without checksum support sees the same traffic
	iid_top #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEND), .REVISION_CODE(REV), .CHECKSUM_CAPABLE(0)) uut_nc (
		.clock(clock), .arst_n(arst_n), .bus(bus), .rd_data(rd_data_nc), .stream(stream),
		.csum_enable(csum_enable_nc), .csum_result(csum_result_nc), .csum_done(csum_done_nc));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_flag(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [31:0] q, output logic [31:0] qn);
		@(posedge clock);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		q = rd_data;
		qn = rd_data_nc;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] w);
		@(posedge clock);
		bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
		#1;
	endtask

	task automatic send_byte(input logic [7:0] b, input logic f, input logic l);
		@(posedge clock);
		stream <= '{valid: 1'b1, first: f, last: l, data: b};
		@(posedge clock);
		stream.valid <= 1'b0;
		#1;
	endtask

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ `IID_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	initial begin
		#20000;
		failures++;
		final_report();
	end

	initial begin
		arst_n = 1'b0;
		bus = '0;
		stream = '0;
		failures = 0;
		compares = 0;
		repeat (2) @(posedge clock);
		#1;
		chk_val("rd_data_reset", 32'h0000_0000, rd_data);
		chk_flag("enable_reset", 1'b0, csum_enable);
		chk_val("result_reset", 32'h0000_0000, {16'h0000, csum_result});
		chk_flag("done_reset", 1'b0, csum_done);
		@(posedge clock);
		arst_n <= 1'b1;
		bus_read(`IID_OFF_ID_LO, d, dn);
		chk_val("id_lo", {REV[7:0], 1'b1, 3'b000, 20'h00000}, d);
		chk_val("id_lo_absent", {REV[7:0], 1'b0, 3'b000, 20'h00000}, dn);
		bus_read(`IID_OFF_ID_HI, d, dn);
		chk_val("id_hi", {DEV[15:0], VEND[7:0], VEND[15:8]}, d);
		@(posedge clock);
		#1;
		chk_val("rd_data_after", 32'h0000_0000, rd_data);
		// Writes of all ones must leave every identifier bit alone
		bus_write(`IID_OFF_ID_LO, 32'hffff_ffff);
		bus_write(`IID_OFF_ID_HI, 32'hffff_ffff);
		bus_read(`IID_OFF_ID_LO, d, dn);
		chk_val("id_lo_wr", {REV[7:0], 1'b1, 3'b000, 20'h00000}, d);
		chk_val("id_lo_wr_absent", {REV[7:0], 1'b0, 3'b000, 20'h00000}, dn);
		bus_read(`IID_OFF_ID_HI, d, dn);
		chk_val("id_hi_wr", {DEV[15:0], VEND[7:0], VEND[15:8]}, d);
		bus_read(`IID_OFF_CSUM_EN, d, dn);
		chk_val("enable_reg", 32'h0000_0000, d);
		chk_val("enable_absent", 32'h0000_00ff, dn);
		bus_read(`IID_OFF_CSUM_RES, d, dn);
		chk_val("result_reg", 32'h0000_0000, d);
		chk_val("result_absent", 32'h0000_00ff, dn);
		bus_write(`IID_OFF_CSUM_EN, 32'h0000_0001);
		chk_flag("enable_on", 1'b1, csum_enable);
		chk_flag("enable_absent_off", 1'b0, csum_enable_nc);
		bus_read(`IID_OFF_CSUM_EN, d, dn);
		chk_val("enable_reg_on", 32'h0000_0001, d);
		chk_val("enable_absent_on", 32'h0000_00ff, dn);
		// Whole frame of three bytes
		e = crc_step(crc_step(crc_step(`IID_CRC_SEED, 8'ha5), 8'h3c), 8'h0f);
		send_byte(8'ha5, 1'b1, 1'b0);
		chk_flag("done_mid", 1'b0, csum_done);
		send_byte(8'h3c, 1'b0, 1'b0);
		send_byte(8'h0f, 1'b0, 1'b1);
		chk_flag("done_frame", 1'b1, csum_done);
		chk_val("crc_frame", {16'h0000, e}, {16'h0000, csum_result});
		@(posedge clock);
		#1;
		chk_flag("done_pulse", 1'b0, csum_done);
		chk_flag("done_absent", 1'b0, csum_done_nc);
		chk_val("crc_absent", 32'h0000_0000, {16'h0000, csum_result_nc});
		bus_write(`IID_OFF_CSUM_RES, 32'h0000_abcd);
		bus_read(`IID_OFF_CSUM_RES, d, dn);
		chk_val("result_read", {16'h0000, e}, d);
		// Byte outside any frame is ignored
		send_byte(8'h77, 1'b0, 1'b1);
		chk_flag("done_stray", 1'b0, csum_done);
		chk_val("crc_stray", {16'h0000, e}, {16'h0000, csum_result});
		// A new first byte restarts the sum
		e2 = crc_step(crc_step(`IID_CRC_SEED, 8'h22), 8'h33);
		send_byte(8'h11, 1'b1, 1'b0);
		send_byte(8'h22, 1'b1, 1'b0);
		send_byte(8'h33, 1'b0, 1'b1);
		chk_flag("done_restart", 1'b1, csum_done);
		chk_val("crc_restart", {16'h0000, e2}, {16'h0000, csum_result});
		// Disabling mid-frame drops the partial frame
		send_byte(8'h44, 1'b1, 1'b0);
		bus_write(`IID_OFF_CSUM_EN, 32'h0000_0000);
		chk_flag("enable_off", 1'b0, csum_enable);
		send_byte(8'h55, 1'b0, 1'b1);
		chk_flag("done_abort", 1'b0, csum_done);
		chk_val("crc_abort", {16'h0000, e2}, {16'h0000, csum_result});
		bus_read(8'h10, d, dn);
		chk_val("unmapped", 32'h0000_0000, d);
		chk_val("unmapped_absent", 32'h0000_0000, dn);
		final_report();
	end
endmodule // tb_top
